// ==== l1dm_arbiter.sv ====
// L1 data memory control and subbank arbiter.
// Assumes all request inputs are synchronous to clock_in.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module l1dm_arbiter
  import l1dm_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              resetn_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [11:0]       paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  input  wire mem_req_t          dag0_in,
  input  wire mem_req_t          dag1_in,
  input  wire mem_req_t          store_in,
  input  wire mem_req_t          dma_in,
  input  wire logic              dma_second_in,
  input  wire mem_req_t          fill_in,
  input  wire logic              fill_dirty_in,
  input  wire logic [1:0]        fill_valid_in,
  input  wire logic              fill_lru_in,
  input  wire mem_req_t          test_in,
  input  wire logic              ifetch_req_in,
  output logic [NRQ-1:0]         grant_out,
  output dag_resp_t              dag0_resp_out,
  output dag_resp_t              dag1_resp_out,
  output logic                   dma_boost_out,
  output logic                   fill_copyback_out,
  output logic                   fill_write_out,
  output line_state_t            fill_line_state_out,
  output logic                   fill_way_out,
  output logic                   ifetch_fault_out
);

  // ****************************************************
  // Registers
  // ****************************************************
  ctrl_t                         ctrl_q;
  logic [NUM_DESC-1:0][31:0]     desc_q;
  logic [4:0]                    dma_cnt_q;
  logic [4:0]                    dma_cnt_d;
  fill_state_t                   fill_q;
  fill_state_t                   fill_d;
  logic [NRQ-1:0]                gnt_d;
  logic [NRQ-1:0]                taken;
  logic                          hit;
  logic [2:0]                    idx;
  logic                          dma_boost_d;

  // ****************************************************
  // APB decode
  // ****************************************************
  wire       setup    = psel_in & ~penable_in & ~pready_out;
  wire       access   = psel_in & penable_in & pready_out;
  wire       is_ctrl  = paddr_in == CTRL_OFF;
  wire       is_stat  = paddr_in == STAT_OFF;
  wire       is_desc  = paddr_in[11:6] == DESC_OFF[11:6] &&
                        paddr_in[1:0] == 2'h0;
  wire [3:0] desc_idx = paddr_in[5:2];
  wire       mapped   = is_ctrl | is_stat | is_desc;
  wire       wr_ctrl  = access & pwrite_in & is_ctrl;
  wire       wr_desc  = access & pwrite_in & is_desc;

  wire [31:0] ctrl_rd =
    (32'(ctrl_q.prot_en)  << CTRL_PROT) |
    (32'(ctrl_q.cfg)      << CTRL_CFG)  |
    (32'(ctrl_q.cbs)      << CTRL_CBS)  |
    (32'(ctrl_q.dag0_sel) << CTRL_PSEL0) |
    (32'(ctrl_q.dag1_sel) << CTRL_PSEL1);
  wire [31:0] stat_rd =
    {25'h0, fill_q == FILL_LINE, dma_boost_d, dma_cnt_q};
  wire [31:0] rd_mux  = is_ctrl ? ctrl_rd :
                        is_stat ? stat_rd :
                        is_desc ? desc_q[desc_idx] : 32'h0;

  // Reserved bits are dropped on write and read as zero
  wire ctrl_t ctrl_wr = '{
    dag1_sel: pwdata_in[CTRL_PSEL1],
    dag0_sel: pwdata_in[CTRL_PSEL0],
    cbs:      pwdata_in[CTRL_CBS],
    cfg:      pwdata_in[CTRL_CFG +: 2],
    prot_en:  pwdata_in[CTRL_PROT]
  };

  // ****************************************************
  // Address classification per requester
  // ****************************************************
  mem_req_t [NRQ-1:0] rq_in;
  assign rq_in = {fill_in, dma_in, store_in,
                  dag1_in, dag0_in, test_in};

  // Bank select only when both banks cache
  wire both_cache = ctrl_q.cfg == CFG_BOTH;
  wire cache_arb  = ctrl_q.cfg != CFG_SRAM;

  logic [NRQ-1:0]      bank_b;
  logic [NRQ-1:0][5:0] key;
  genvar r;
  generate
    for (r = 0; r < NRQ; r++) begin : g_rq
      wire [31:0] a = rq_in[r].addr;
      // Selector from bit 14 or bit 23
      wire sel = ctrl_q.cbs ? a[23] : a[14];
      // Selector 0 goes to bank B
      assign bank_b[r] = both_cache & ~sel;
      assign key[r] = cache_arb ?
        {2'h0, bank_b[r], a[16], a[13:12]} :
        {a[21:20], a[16], a[13:12], a[2]};
    end
  endgenerate

  // ****************************************************
  // Protection descriptor lookup
  // ****************************************************
  // Descriptor word: [31:22] page, [3:2] mode,
  // [1] cacheable, [0] valid
  logic [1:0][NUM_DESC-1:0] dmatch;
  genvar e;
  generate
    for (e = 0; e < NUM_DESC; e++) begin : g_desc
      assign dmatch[0][e] = ctrl_q.prot_en & desc_q[e][0] &
        desc_q[e][31:22] == dag0_in.addr[31:22];
      assign dmatch[1][e] = ctrl_q.prot_en & desc_q[e][0] &
        desc_q[e][31:22] == dag1_in.addr[31:22];
    end
  endgenerate

  logic [1:0][31:0] dsel;
  always_comb begin
    dsel = '0;
    for (int d = 0; d < 2; d++) begin
      for (int k = NUM_DESC - 1; k >= 0; k--) begin
        if (dmatch[d][k]) begin
          dsel[d] = desc_q[k];
        end
      end
    end
  end

  // ****************************************************
  // Address generator checks and steering
  // ****************************************************
  dag_resp_t [1:0] resp_d;
  logic      [1:0] dag_rq;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_dag
      wire mem_req_t q = g ? dag1_in : dag0_in;
      wire in_l1  = q.addr[31:22] == L1_TOP;
      wire in_mmr = q.addr[31:21] == MMR_TOP;
      wire l2     = ~in_l1 & ~in_mmr;
      wire no_mem = in_l1 & (q.addr[21:0] >= L1_SIZE);
      wire misal  = (q.size == SIZE_WORD && q.addr[1:0] != 2'h0)
                  | (q.size == SIZE_HALF && q.addr[0]);
      wire mmr_bad = in_mmr & ((g == 1) | q.user);
      wire unmapped = ctrl_q.prot_en & l2 & ~|dmatch[g];
      wire fault = q.valid &
                   (no_mem | misal | mmr_bad | unmapped);
      wire cach = q.valid & l2 & cache_arb &
                  ctrl_q.prot_en & |dmatch[g] & dsel[g][1];
      wire [1:0] mode = dsel[g][3:2];
      wire psel = g ? ctrl_q.dag1_sel : ctrl_q.dag0_sel;
      assign resp_d[g].fault     = fault;
      assign resp_d[g].cacheable = cach & ~fault;
      assign resp_d[g].port      = cach ? bank_b[g + 1] : psel;
      assign resp_d[g].bank_b    = bank_b[g + 1];
      // Write allocation depends on page mode
      assign resp_d[g].allocate  = cach & ~fault &
        (~q.write | mode != MODE_WT_RD);
      assign resp_d[g].mode      = mode;
      assign dag_rq[g] = q.valid & ~fault & (in_l1 | cach);
    end
  endgenerate

  // ****************************************************
  // Collision arbitration
  // ****************************************************
  // Boost after more than 16 blocked clocks
  assign dma_boost_d = (dma_cnt_q > DMA_LIMIT) | dma_second_in;

  logic [NRQ-1:0] want;
  assign want = {fill_in.valid, dma_in.valid, store_in.valid,
                 dag_rq[1], dag_rq[0], test_in.valid};

  wire [5:0][2:0] order = cache_arb   ? ORD_CACHE :
                          dma_boost_d ? ORD_BOOST : ORD_SRAM;

  // Requests on distinct keys all win together
  always_comb begin
    gnt_d = '0;
    taken = '0;
    hit   = 1'b0;
    idx   = 3'h0;
    for (int p = 0; p < NRQ; p++) begin
      idx = order[p];
      hit = 1'b0;
      for (int t = 0; t < NRQ; t++) begin
        if (taken[t] && key[t] == key[idx]) begin
          hit = 1'b1;
        end
      end
      if (want[idx] && !hit) begin
        gnt_d[idx] = 1'b1;
        taken[idx] = 1'b1;
      end
    end
  end

  // Counter clears on grant, saturates otherwise
  assign dma_cnt_d = gnt_d[RQ_DMA] ? 5'h00 :
    (dma_in.valid && dma_cnt_q != 5'h1f) ?
      dma_cnt_q + 5'h01 : dma_cnt_q;

  // ****************************************************
  // Line fill with copyback of dirty victim
  // ****************************************************
  wire fill_go = gnt_d[RQ_FILL];
  // Dirty victim goes out before the new line
  wire copyback = fill_go & fill_q == FILL_IDLE & fill_dirty_in;
  wire line_wr  = fill_go & ~copyback;
  assign fill_d = copyback ? FILL_LINE :
                  line_wr  ? FILL_IDLE : fill_q;

  // Two ways: invalid way first, else LRU
  wire way_d = ~fill_valid_in[0] ? 1'b0 :
               ~fill_valid_in[1] ? 1'b1 : fill_lru_in;
  wire line_state_t state_d =
    (fill_in.write && dsel[0][3:2] == MODE_WB) ?
      LINE_DIRTY : LINE_CLEAN;

  // ****************************************************
  // State and outputs
  // ****************************************************
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // SRAM only, protection off after reset
      ctrl_q <= CTRL_RESET;
      desc_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wr;
      end
      if (wr_desc) begin
        desc_q[desc_idx] <= pwdata_in;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup;
      prdata_out  <= (setup & ~pwrite_in) ? rd_mux : 32'h0;
      pslverr_out <= setup & ~mapped;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dma_cnt_q     <= 5'h00;
      dma_boost_out <= 1'b0;
      grant_out     <= '0;
      dag0_resp_out <= '0;
      dag1_resp_out <= '0;
    end else begin
      dma_cnt_q     <= dma_cnt_d;
      dma_boost_out <= dma_boost_d;
      grant_out     <= gnt_d;
      dag0_resp_out <= resp_d[0];
      dag1_resp_out <= resp_d[1];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fill_q              <= FILL_IDLE;
      fill_copyback_out   <= 1'b0;
      fill_write_out      <= 1'b0;
      fill_line_state_out <= LINE_INVALID;
      fill_way_out        <= 1'b0;
      ifetch_fault_out    <= 1'b0;
    end else begin
      fill_q              <= fill_d;
      fill_copyback_out   <= copyback;
      fill_write_out      <= line_wr;
      fill_line_state_out <= line_wr ? state_d : LINE_INVALID;
      fill_way_out        <= way_d;
      ifetch_fault_out    <= ifetch_req_in;
    end
  end

endmodule // l1dm_arbiter

// ==== l1dm_pkg.sv ====
// Constants, types and register map of the L1 data memory arbiter.
// Assumes a single core clock and an APB master on the register side.
//
// Functional notes
// - Collision-free traffic all served in one clock
// - Data memory never serves instruction fetches
// - Generator 1 select steers its uncached fetches
// - Generator 0 select steers its uncached fetches
// - Cacheable fetches use their cache bank port
// - Bank select acts only when config is 11
// - Bank select picks address bit 14 or 23
// - Protection enable gates all 16 entries, reset off
// - Minimal checks still fault when protection off
// - Reset leaves all memory as SRAM
// - Cache L2 only if configured, enabled, cacheable
// - SRAM collision needs bits 2,13:12,16,21:20 equal
// - SRAM priority: generators, store, then DMA/fill
// - DMA boosted in SRAM mode after more than 16 blocked clocks or queueing
// - Two-way cache, second bank adds sets
// - Cache collision: same subbank, half bank, bank
// - Cache priority: test, generators, store, fill, then DMA
// - Three per-page cache modes from descriptors
// - Selector 0 routes bank B, 1 bank A
// - Dirty victim copied back before line overwrite
package l1dm_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [11:0] CTRL_OFF     = 12'h000;
  localparam logic [11:0] STAT_OFF     = 12'h004;
  localparam logic [11:0] DESC_OFF     = 12'h100;
  localparam int          CTRL_PROT    = 1;
  localparam int          CTRL_CFG     = 2;
  localparam int          CTRL_CBS     = 4;
  localparam int          CTRL_PSEL0   = 12;
  localparam int          CTRL_PSEL1   = 13;
  localparam logic [1:0]  CFG_SRAM     = 2'h0;
  localparam logic [1:0]  CFG_BOTH     = 2'h3;
  localparam int          NUM_DESC     = 16;
  localparam logic [4:0]  DMA_LIMIT    = 5'h10;

  // Address regions (top bits of a 32-bit address)
  localparam logic [9:0]  L1_TOP       = 10'h3fe;
  localparam logic [21:0] L1_SIZE      = 22'h010000;
  localparam logic [10:0] MMR_TOP      = 11'h7ff;

  // ****************************************************
  // Requesters and priority orders (slot 0 first)
  // ****************************************************
  localparam int NRQ = 6;
  localparam int RQ_TEST = 0;
  localparam int RQ_DAG0 = 1;
  localparam int RQ_DAG1 = 2;
  localparam int RQ_STORE = 3;
  localparam int RQ_DMA  = 4;
  localparam int RQ_FILL = 5;
  localparam logic [5:0][2:0] ORD_SRAM =
    {3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
  localparam logic [5:0][2:0] ORD_BOOST =
    {3'h0, 3'h5, 3'h3, 3'h2, 3'h1, 3'h4};
  localparam logic [5:0][2:0] ORD_CACHE =
    {3'h4, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    MODE_WT_RD, MODE_WT_RW, MODE_WB
  } cache_mode_t;

  typedef enum logic [1:0] {
    LINE_INVALID, LINE_CLEAN, LINE_DIRTY
  } line_state_t;

  typedef enum logic {
    FILL_IDLE, FILL_LINE
  } fill_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        user;
    logic [1:0]  size;
    logic [31:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic       fault;
    logic       cacheable;
    logic       port;
    logic       bank_b;
    logic       allocate;
    logic [1:0] mode;
  } dag_resp_t;

  typedef struct packed {
    logic dag1_sel;
    logic dag0_sel;
    logic cbs;
    logic [1:0] cfg;
    logic prot_en;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 6'h00;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

endpackage

// ==== l1dm_arbiter_checker.sv ====
// Port relations of the L1 data memory arbiter.
// Bound into l1dm_arbiter; sees its ports only.
`timescale 1ns/1ps
module l1dm_arbiter_checker
  import l1dm_pkg::*;
(
  input wire logic           clock_in,
  input wire logic           resetn_in,
  input wire logic           psel_in,
  input wire logic           penable_in,
  input wire logic           pready_out,
  input wire logic [31:0]    prdata_out,
  input wire logic           pslverr_out,
  input wire mem_req_t       dma_in,
  input wire logic           dma_second_in,
  input wire logic           ifetch_req_in,
  input wire logic [NRQ-1:0] grant_out,
  input wire dag_resp_t      dag0_resp_out,
  input wire logic           dma_boost_out,
  input wire logic           fill_write_out,
  input wire line_state_t    fill_line_state_out,
  input wire logic           ifetch_fault_out
);
  // ****************************************
  // Assertions
  // ****************************************
  logic [5:0] blk_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Cycles a DMA request has stood ungranted
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) blk_q <= 6'h00;
    else if (!dma_in.valid || grant_out[RQ_DMA]) blk_q <= 6'h00;
    else if (blk_q != 6'h3f) blk_q <= blk_q + 6'h01;
  end
  sequence apb_setup;
    psel_in && !penable_in;
  endsequence
  a_apb_ready_next: assert property (apb_setup |=> pready_out)
    else $error("no ready after setup");
  a_apb_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_apb_idle_zero: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside access");
  a_ifetch_refused: assert property (ifetch_req_in |=> ifetch_fault_out)
    else $error("fetch not refused");
  a_grant_cause: assert property (grant_out[RQ_DMA] |-> $past(dma_in.valid))
    else $error("grant without request");
  a_fault_no_grant: assert property
    (dag0_resp_out.fault |-> !grant_out[RQ_DAG0])
    else $error("faulting access granted");
  a_second_boost: assert property
    (dma_in.valid && dma_second_in |=> dma_boost_out)
    else $error("queued dma not boosted");
  a_dma_wait_bound: assert property (blk_q <= 6'h14)
    else $error("dma starved");
  a_line_state: assert property
    (fill_write_out == (fill_line_state_out != LINE_INVALID))
    else $error("line state mismatch");
endmodule // l1dm_arbiter_checker

bind l1dm_arbiter l1dm_arbiter_checker u_chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out),
  .prdata_out(prdata_out), .pslverr_out(pslverr_out), .dma_in(dma_in),
  .dma_second_in(dma_second_in), .ifetch_req_in(ifetch_req_in),
  .grant_out(grant_out), .dag0_resp_out(dag0_resp_out),
  .dma_boost_out(dma_boost_out), .fill_write_out(fill_write_out),
  .fill_line_state_out(fill_line_state_out),
  .ifetch_fault_out(ifetch_fault_out));

// ==== l2_fill_model.sv ====
// Line fill source at the L2 side, with a dirty victim.
// Assumes registered copyback and write pulses from the arbiter.
`timescale 1ns/1ps
module l2_fill_model
  import l1dm_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  input  wire logic copyback_in,
  input  wire logic write_in,
  output mem_req_t   fill_out,
  output logic       dirty_out,
  output logic [1:0] valid_out,
  output logic       done_out
);
  logic [1:0] st_q;
  assign valid_out = 2'h1;
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= 2'h0;
      fill_out <= '0;
      dirty_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      case (st_q)
        2'h0: if (start_in) begin
          fill_out <= '{1'b1, 1'b1, 1'b0, SIZE_WORD, 32'h0};
          dirty_out <= 1'b1;
          st_q <= 2'h1;
        end
        2'h1: if (write_in) st_q <= 2'h3;
          else if (copyback_in) begin
          dirty_out <= 1'b0;
          st_q <= 2'h2;
        end
        2'h2: if (write_in) begin
          fill_out.valid <= 1'b0;
          fill_out.addr <= ~fill_out.addr;
          done_out <= 1'b1;
          st_q <= 2'h0;
        end
        default: st_q <= st_q;
      endcase
    end
  end
endmodule // l2_fill_model

// ==== test_l1dm_arbiter.sv ====
// Self-checking bench of the L1 data memory arbiter.
// APB and requests driven here; fill traffic from l2_fill_model.
`timescale 1ns/1ps
module test_l1dm_arbiter;
  import l1dm_pkg::*;
  localparam logic [31:0] L1  = 32'hff800000;
  localparam logic [31:0] MMR = 32'hffe00000;
  localparam logic [31:0] OFS [5] = '{32'h8, 32'h4000, 32'h4, 32'h1000, 32'h2000};
  localparam logic [31:0] CA [4] = '{32'h0, 32'h4000, 32'h800000, 32'h4000};
  localparam logic [3:0]  CB = 4'b1100;
  localparam logic [3:0]  BB = 4'b1001;
  localparam mem_req_t    NO = '0;
  logic        clock_in, resetn_in, psel, penable, pwrite, dma_second, ifetch;
  logic        start, pready, pslverr, boost, cpb, fwr, fway, ifault, fdirty;
  logic        done, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  fvalid;
  logic [5:0]  grant;
  mem_req_t    dag0, dag1, store, dma, fill;
  dag_resp_t   r0, r1;
  line_state_t lstate;
  int          n_fail, n_tests, cyc, n;

  l1dm_arbiter u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .dag0_in(dag0),
    .dag1_in(dag1), .store_in(store), .dma_in(dma),
    .dma_second_in(dma_second), .fill_in(fill), .fill_dirty_in(fdirty),
    .fill_valid_in(fvalid), .fill_lru_in(1'b0), .test_in(NO),
    .ifetch_req_in(ifetch), .grant_out(grant), .dag0_resp_out(r0),
    .dag1_resp_out(r1), .dma_boost_out(boost), .fill_copyback_out(cpb),
    .fill_write_out(fwr), .fill_line_state_out(lstate),
    .fill_way_out(fway), .ifetch_fault_out(ifault));
  l2_fill_model u_l2 (.clock_in(clock_in), .resetn_in(resetn_in),
    .start_in(start), .copyback_in(cpb), .write_in(fwr), .fill_out(fill),
    .dirty_out(fdirty), .valid_out(fvalid), .done_out(done));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic mem_req_t mk(input logic [31:0] a, input logic u);
    mk = '{1'b1, 1'b0, u, SIZE_WORD, a};
  endfunction
  function automatic mem_req_t off(input mem_req_t r);
    off = r;
    off.valid = 1'b0;
    off.addr = ~r.addr;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    // Answer and read data are taken at the edge that sees pready high
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rq(input mem_req_t a0, a1, st, dm);
    @(posedge clock_in);
    dag0 <= a0; dag1 <= a1; store <= st; dma <= dm;
    @(posedge clock_in);
    dag0 <= off(a0); dag1 <= off(a1); store <= off(st); dma <= off(dm);
    #1;
  endtask

  initial begin
    resetn_in = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; dag0 = NO; dag1 = NO; store = NO;
    dma = NO; dma_second = 1'b0; ifetch = 1'b0; start = 1'b0;
    n_fail = 0; n_tests = 0; cyc = 0;
    repeat (16) @(posedge clock_in);
    resetn_in <= 1'b1;
    apb(1'b0, CTRL_OFF, 32'h0); chk(rd, 32'h0);
    apb(1'b1, CTRL_OFF, 32'h0000301e);
    apb(1'b0, CTRL_OFF, 32'h0); chk(rd, 32'h0000301e);
    apb(1'b0, 12'h080, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, CTRL_OFF, 32'h0);
    $display("registers done");
    for (int i = 0; i < 5; i++) begin
      rq(mk(L1, 0), NO, NO, mk(L1 + OFS[i], 0));
      chk({26'h0, grant}, i < 2 ? 32'h02 : 32'h12);
    end
    rq(NO, NO, mk(L1, 0), mk(L1 + 32'h8, 0));
    chk({26'h0, grant}, 32'h08);
    rq(mk(L1, 0), NO, mk(L1, 0), NO);
    chk({26'h0, grant}, 32'h02);
    rq(mk(L1, 0), mk(L1 + 32'h4, 0), mk(L1 + 32'h1000, 0),
       mk(L1 + 32'h2000, 0));
    chk({26'h0, grant}, 32'h1e);
    @(posedge clock_in);
    dag0 <= mk(L1, 0);
    dma <= mk(L1, 0);
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (grant[RQ_DMA] !== 1'b1 && n < 40);
    dag0 <= off(dag0);
    dma <= off(dma);
    chk({31'h0, n >= 17 && n <= 20}, 32'h1);
    // Request stands one cycle past its grant: one blocked count
    apb(1'b0, STAT_OFF, 32'h0); chk(rd & 32'h1f, 32'h1);
    dma_second <= 1'b1;
    rq(mk(L1, 0), NO, NO, mk(L1, 0));
    chk({26'h0, grant}, 32'h10);
    @(posedge clock_in);
    dma_second <= 1'b0;
    $display("arbitration done");
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, CTRL_OFF, p == 1 ? 32'h1000 : 32'h2000);
      rq(mk(32'h1000, 0), mk(32'h2000, 0), NO, NO);
      chk({30'h0, r0.port, r1.port}, p == 1 ? 32'h2 : 32'h1);
    end
    rq(mk(MMR, 1), mk(MMR, 0), NO, NO);
    chk({30'h0, r0.fault, r1.fault}, 32'h3);
    rq(mk(L1 + 32'h1, 0), mk(L1 + 32'h10000, 0), NO, NO);
    chk({30'h0, r0.fault, r1.fault}, 32'h3);
    rq(mk(MMR, 0), NO, NO, NO); chk({31'h0, r0.fault}, 32'h0);
    $display("steering done");
    apb(1'b1, DESC_OFF, 32'hb);
    apb(1'b1, DESC_OFF + 12'h004, 32'h0080000b);
    apb(1'b1, CTRL_OFF, 32'hc);
    rq(mk(32'h0, 0), NO, NO, NO); chk({31'h0, r0.cacheable}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_OFF, CB[i] ? 32'h1e : 32'he);
      rq(mk(CA[i], 0), NO, NO, NO);
      chk({27'h0, r0.cacheable, r0.allocate, r0.bank_b, r0.mode},
          {27'h0, 1'b1, 1'b1, BB[i], 2'h2});
    end
    @(posedge clock_in);
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk({31'h0, done}, 32'h1);
    chk({31'h0, fway}, 32'h1);
    @(posedge clock_in);
    ifetch <= 1'b1;
    @(posedge clock_in);
    ifetch <= 1'b0;
    #1;
    chk({31'h0, ifault}, 32'h1);
    $display("cache done");
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    apb(1'b0, CTRL_OFF, 32'h0); chk(rd, 32'h0);
    $display("reset done");
    wrap_up();
  end
endmodule // test_l1dm_arbiter
